// ---- dsi_pkg.sv ----
package dsi_pkg;
	// Clock and evaluation tick
	localparam int CLK_NS   = 8;
	localparam int TICK_US  = 100;
	localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;

	// Documented default times, in microseconds
	localparam int FILTER_US    = 10000;
	localparam int TOL_US       = 10000;
	localparam int TP_PERIOD_US = 10000000;
	localparam int TP_PULSE_US  = 1000;

	// Time counters count evaluation ticks
	localparam int TW = 20;
	localparam logic [TW-1:0] FILTER_TICKS    = TW'(FILTER_US / TICK_US);
	localparam logic [TW-1:0] TOL_TICKS       = TW'(TOL_US / TICK_US);
	localparam logic [TW-1:0] TP_PERIOD_TICKS = TW'(TP_PERIOD_US / TICK_US);
	localparam logic [TW-1:0] TP_PULSE_TICKS  = TW'(TP_PULSE_US / TICK_US);

	// Channel layout: input i uses channels 2i and 2i+1, brake feedback j uses 6+j
	localparam int N_IN   = 3;
	localparam int N_BFB  = 2;
	localparam int N_CH   = 2 * N_IN + N_BFB;
	localparam int CH_BFB = 2 * N_IN;
	localparam int N_FUNC = 18;

	// Latched error bits
	localparam int E_MISS  = 0;
	localparam int E_CROSS = 5;
	localparam int E_DISC  = 9;
	localparam int E_W     = 12;

	localparam logic LVL_RST = 1'b0;

	typedef enum logic [4:0] {
		F_NONE, F_TORQUE_OFF, F_BRAKE_CTRL, F_STOP_ONE, F_LIM_SPEED, F_SPEED_MON,
		F_DOOR_LOCK, F_LIM_ACCEL, F_FS_RESET, F_IDX0, F_IDX1, F_IDX2,
		F_FB_CHECK_A, F_FB_CHECK_B, F_FB_WARN_A, F_FB_WARN_B,
		F_BRK_TEST_PLUS, F_BRK_TEST_MINUS
	} dsi_func_t;

	typedef enum logic [1:0] {BM_OFF, BM_CROSS, BM_SEPARATE} dsi_bmode_t;
	typedef enum logic [1:0] {BD_OFF, BD_CHECK_A, BD_CHECK_B} dsi_bdiag_t;
endpackage

// ---- dsi_chan_if.sv ----
`timescale 1ns/1ps
interface dsi_chan_if (
	input logic clk,
	input logic nrst
);
	logic                    tick;
	logic                    x;
	logic                    mon_en;
	logic [dsi_pkg::TW-1:0]  filt;
	logic [dsi_pkg::TW-1:0]  pulse;
	logic [dsi_pkg::TW-1:0]  period;
	logic                    level;
	logic                    in_pulse;
	logic                    pulse_ok;
	logic                    miss;

	modport top (input clk, nrst, level, in_pulse, pulse_ok, miss,
		output tick, x, mon_en, filt, pulse, period);
	modport chan (input clk, nrst, tick, x, mon_en, filt, pulse, period,
		output level, in_pulse, pulse_ok, miss);
endinterface

// ---- dsi_chan.sv ----
`timescale 1ns/1ps
module dsi_chan (
	dsi_chan_if.chan c
);
	localparam int TW = dsi_pkg::TW;

	logic [TW-1:0] flt_q;
	logic [TW-1:0] flt_d;
	logic [TW-1:0] dark_q;
	logic [TW-1:0] dark_d;
	logic [TW-1:0] per_q;
	logic [TW-1:0] per_d;
	logic          level_q;
	logic          level_d;
	logic          ok_q;
	logic          miss_q;
	logic          miss_d;

	// x is normalised: 1 is the idle (not executed) level
	wire          diff       = c.x != level_q;
	// A drop from idle must outlast filter plus pulse length when pulses are expected
	wire [TW:0]   limit      = {1'b0, c.filt} + ((c.mon_en && level_q) ? {1'b0, c.pulse} : '0);
	wire          flt_hit    = c.tick && diff && ({1'b0, flt_q} >= limit);
	wire          dark       = level_q && !c.x;
	wire          pulse_end  = level_q && c.x && (dark_q != '0);
	wire          pulse_good = pulse_end && (dark_q >= c.pulse);
	wire          per_clr    = !c.mon_en || !level_q || pulse_good;

	assign level_d = flt_hit ? c.x : level_q;
	assign flt_d   = !diff ? '0 : ((c.tick && flt_q != '1) ? flt_q + TW'(1) : flt_q);
	assign dark_d  = !dark ? '0 : ((c.tick && dark_q != '1) ? dark_q + TW'(1) : dark_q);
	assign per_d   = per_clr ? '0 : ((c.tick && per_q != '1) ? per_q + TW'(1) : per_q);
	assign miss_d  = c.mon_en && level_q && (per_q >= c.period);

	always_ff @(posedge c.clk or negedge c.nrst) begin
		if (!c.nrst) begin
			level_q <= dsi_pkg::LVL_RST;
			flt_q   <= '0;
			dark_q  <= '0;
			per_q   <= '0;
			ok_q    <= 1'b0;
			miss_q  <= 1'b0;
		end else begin
			level_q <= level_d;
			flt_q   <= flt_d;
			dark_q  <= dark_d;
			per_q   <= per_d;
			ok_q    <= pulse_good;
			miss_q  <= miss_d;
		end
	end

	assign c.level    = level_q;
	assign c.in_pulse = dark;
	assign c.pulse_ok = ok_q;
	assign c.miss     = miss_q;

	default clocking cb @(posedge c.clk);
	endclocking
	default disable iff (!c.nrst);

	a_filter_wait: assert property ($changed(level_q) |-> $past(flt_hit))
		else $error("level changed before filter time");
	a_pulse_masked: assert property ((level_q && c.mon_en && !c.x && dark_q < c.pulse) |=> level_q)
		else $error("test pulse taken as request");
	a_miss_cause: assert property ($rose(miss_q) |-> $past(c.mon_en && per_q >= c.period))
		else $error("missing pulse flagged early");
endmodule

// ---- dsi_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - Three two-channel inputs, each pair evaluated as one logical input.
// - A level change counts only after it persisted for the filter time.
// - Separate filter times for inputs one, two, three and brake feedback.
// - Configurable test pulse period and length, defaults 10 s and 1 ms.
// - Missing or too short test pulse within one period enters safe state.
// - Test pulses on both channels of one input flag cross circuit.
// - A test pulse of configured length never requests the linked function.
// - Test pulse monitoring enabled separately for each two-channel input.
// - Brake cross mode flags coincident pulses on both brake feedback inputs.
// - Brake separate mode checks pulses but allows them to coincide.
// - Each input requests up to two functions; shared functions are AND linked.
// - Selectable functions cover stops, limits, reset, index bits, brake checks.
// - A fail-safe reset input clears the fail-safe status bit.
// - Three index selection inputs form an index, bit 0 least significant.
// - Equivalent mode: both channels alike, 0V executes, 24V does not.
// - Antivalent mode: a high b low idle, a low b high executes.
// - Channel disagreement longer than tolerance time enters safe state.
// - Reaction delay is filter time per input, plus test pulse length when pulse monitoring is enabled.
// - Each brake feedback has two assignments, each with its activation level.
// - Brake feedback check reacts once its waiting time has elapsed.
// - Assignment selects off, first or second brake feedback check.
module dsi_top #(
	parameter int TICK_CYC = dsi_pkg::TICK_CYC
) (
	input  wire logic                                  mclk_i,
	input  wire logic                                  nrst_i,
	input  wire logic [dsi_pkg::N_IN-1:0]              chan_a_i,
	input  wire logic [dsi_pkg::N_IN-1:0]              chan_b_i,
	input  wire logic [dsi_pkg::N_BFB-1:0]             bfb_i,
	input  wire logic [3:0][dsi_pkg::TW-1:0]           filt_ticks_i,
	input  wire logic [dsi_pkg::N_IN-1:0][dsi_pkg::TW-1:0] tol_ticks_i,
	input  wire logic [dsi_pkg::TW-1:0]                tp_period_i,
	input  wire logic [dsi_pkg::TW-1:0]                tp_pulse_i,
	input  wire logic [dsi_pkg::N_IN-1:0]              tp_en_i,
	input  wire dsi_pkg::dsi_bmode_t                   bfb_mode_i,
	input  wire logic [dsi_pkg::N_IN-1:0]              antival_i,
	input  wire dsi_pkg::dsi_func_t                    sel_first_i [dsi_pkg::N_IN],
	input  wire dsi_pkg::dsi_func_t                    sel_second_i [dsi_pkg::N_IN],
	input  wire logic [1:0][1:0]                       bfb_lvl_i,
	input  wire dsi_pkg::dsi_bdiag_t                   bfb_diag_i [4],
	input  wire logic [dsi_pkg::TW-1:0]                fb_wait_i,
	input  wire logic                                  fs_set_i,
	output logic [dsi_pkg::N_FUNC-1:0]                 func_exec_o,
	output logic [2:0]                                 index_o,
	output logic                                       fs_status_o,
	output logic [1:0]                                 fb_trip_o,
	output logic [dsi_pkg::N_IN-1:0]                   in_level_o,
	output logic [dsi_pkg::E_W-1:0]                    err_o,
	output logic                                       safe_state_o
);
	localparam int TW    = dsi_pkg::TW;
	localparam int N_IN  = dsi_pkg::N_IN;
	localparam int N_CH  = dsi_pkg::N_CH;
	localparam int CH_B  = dsi_pkg::CH_BFB;
	localparam int N_F   = dsi_pkg::N_FUNC;
	localparam int EC    = dsi_pkg::E_CROSS;
	localparam int ED    = dsi_pkg::E_DISC;

	function automatic logic sel_hit(input dsi_pkg::dsi_func_t s, input int f);
		sel_hit = (s == dsi_pkg::dsi_func_t'(f));
	endfunction

	// Pin synchronisers
	logic [N_CH-1:0]        s1_q;
	logic [N_CH-1:0]        s2_q;
	logic [15:0]            tick_cnt_q;
	logic                   tick_q;
	logic [N_CH-1:0]        lvl;
	logic [N_CH-1:0]        in_pulse;
	logic [N_CH-1:0]        miss;
	logic [N_IN-1:0]        ok_lvl;
	logic [N_IN-1:0]        disc;
	logic [N_IN-1:0][TW-1:0] tol_q;
	logic [dsi_pkg::E_W-1:0] err_q;
	logic [dsi_pkg::E_W-1:0] err_set;
	logic [N_F-1:0]         asg;
	logic [N_F-1:0]         rel;
	logic [N_F-1:0]         exec_d;
	logic [N_F-1:0]         exec_q;
	logic [2:0]             index_q;
	logic                   fs_q;
	logic                   safe_q;
	logic [N_IN-1:0]        lvl_out_q;
	logic [1:0]             fb_prev_q;
	logic [1:0]             fb_run;
	logic [1:0][TW-1:0]     fb_tmr_q;
	logic [1:0]             fb_trip_q;

	wire [N_CH-1:0] raw = {bfb_i, chan_b_i, chan_a_i};

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end

	// Evaluation tick
	wire tick_wrap = (tick_cnt_q == 16'(TICK_CYC - 1));

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 16'h0001;
			tick_q     <= tick_wrap;
		end
	end

	// Channel evaluators
	dsi_chan_if ch_if [N_CH] (.clk(mclk_i), .nrst(nrst_i));

	genvar g;
	generate
		for (g = 0; g < N_IN; g++) begin : g_in
			// Channel b is inverted in antivalent mode so both read 1 when idle
			assign ch_if[2*g].x        = s2_q[g];
			assign ch_if[2*g+1].x      = s2_q[N_IN+g] ^ antival_i[g];
			assign ch_if[2*g].mon_en   = tp_en_i[g];
			assign ch_if[2*g+1].mon_en = tp_en_i[g];
			assign ch_if[2*g].filt     = filt_ticks_i[g];
			assign ch_if[2*g+1].filt   = filt_ticks_i[g];
		end
		for (g = 0; g < dsi_pkg::N_BFB; g++) begin : g_bfb
			assign ch_if[CH_B+g].x      = s2_q[CH_B+g];
			assign ch_if[CH_B+g].mon_en = (bfb_mode_i != dsi_pkg::BM_OFF);
			assign ch_if[CH_B+g].filt   = filt_ticks_i[3];
		end
		for (g = 0; g < N_CH; g++) begin : g_ch
			assign ch_if[g].tick   = tick_q;
			assign ch_if[g].pulse  = tp_pulse_i;
			assign ch_if[g].period = tp_period_i;
			assign lvl[g]          = ch_if[g].level;
			assign in_pulse[g]     = ch_if[g].in_pulse;
			assign miss[g]         = ch_if[g].miss;
			dsi_chan u_chan (
				.c (ch_if[g])
			);
		end
	endgenerate

	// Pair checks per logical input
	generate
		for (g = 0; g < N_IN; g++) begin : g_pair
			assign ok_lvl[g] = lvl[2*g] & lvl[2*g+1];
			assign disc[g]   = lvl[2*g] ^ lvl[2*g+1];
			assign err_set[dsi_pkg::E_MISS+g] = miss[2*g] | miss[2*g+1];
			assign err_set[EC+g] = tp_en_i[g] & in_pulse[2*g] & in_pulse[2*g+1];
			assign err_set[ED+g] = disc[g] & (tol_q[g] > tol_ticks_i[g]);

			always_ff @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					tol_q[g] <= '0;
				end else if (!disc[g]) begin
					tol_q[g] <= '0;
				end else if (tick_q && tol_q[g] != '1) begin
					tol_q[g] <= tol_q[g] + TW'(1);
				end
			end
		end
	endgenerate

	assign err_set[dsi_pkg::E_MISS+3] = miss[CH_B];
	assign err_set[dsi_pkg::E_MISS+4] = miss[CH_B+1];
	// Separate mode keeps the pulse checks but allows coincident pulses
	assign err_set[EC+3] = (bfb_mode_i == dsi_pkg::BM_CROSS)
		& in_pulse[CH_B] & in_pulse[CH_B+1];

	// Errors latch until reset
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			err_q  <= '0;
			safe_q <= 1'b0;
		end else begin
			err_q  <= err_q | err_set;
			safe_q <= safe_q | (|err_q);
		end
	end

	// Function requests: a function is released only while every assigned input is idle
	generate
		for (g = 0; g < N_F; g++) begin : g_func
			wire [N_IN-1:0] hit;
			genvar k;
			for (k = 0; k < N_IN; k++) begin : g_hit
				assign hit[k] = sel_hit(sel_first_i[k], g) | sel_hit(sel_second_i[k], g);
			end
			assign asg[g] = |hit;
			assign rel[g] = &(~hit | ok_lvl);
		end
	endgenerate

	// Code zero selects nothing
	assign exec_d = asg & ~rel & ~(N_F'(1));

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			exec_q    <= '0;
			index_q   <= '0;
			lvl_out_q <= '0;
		end else begin
			exec_q    <= exec_d;
			index_q   <= {asg[dsi_pkg::F_IDX2] & rel[dsi_pkg::F_IDX2],
				asg[dsi_pkg::F_IDX1] & rel[dsi_pkg::F_IDX1],
				asg[dsi_pkg::F_IDX0] & rel[dsi_pkg::F_IDX0]};
			lvl_out_q <= ok_lvl;
		end
	end

	// Fail-safe status: a set request on fs_set_i wins over a reset request in the same cycle
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fs_q <= 1'b0;
		end else if (fs_set_i) begin
			fs_q <= 1'b1;
		end else if (exec_d[dsi_pkg::F_FS_RESET]) begin
			fs_q <= 1'b0;
		end
	end

	// Brake feedback assignments: slot index is 2*brake + assignment
	wire [3:0] fb_act;
	generate
		for (g = 0; g < 4; g++) begin : g_fbasg
			assign fb_act[g] = (lvl[CH_B+g/2] == bfb_lvl_i[g/2][g%2]);
		end
	endgenerate

	assign fb_run[0] = exec_d[dsi_pkg::F_FB_CHECK_A]
		| (fb_act[0] & (bfb_diag_i[0] == dsi_pkg::BD_CHECK_A))
		| (fb_act[1] & (bfb_diag_i[1] == dsi_pkg::BD_CHECK_A))
		| (fb_act[2] & (bfb_diag_i[2] == dsi_pkg::BD_CHECK_A))
		| (fb_act[3] & (bfb_diag_i[3] == dsi_pkg::BD_CHECK_A));
	assign fb_run[1] = exec_d[dsi_pkg::F_FB_CHECK_B]
		| (fb_act[0] & (bfb_diag_i[0] == dsi_pkg::BD_CHECK_B))
		| (fb_act[1] & (bfb_diag_i[1] == dsi_pkg::BD_CHECK_B))
		| (fb_act[2] & (bfb_diag_i[2] == dsi_pkg::BD_CHECK_B))
		| (fb_act[3] & (bfb_diag_i[3] == dsi_pkg::BD_CHECK_B));

	wire fb_chg = (lvl[CH_B+1:CH_B] != fb_prev_q);

	generate
		for (g = 0; g < 2; g++) begin : g_fbchk
			// A state change on the feedback lines restarts the wait
			always_ff @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					fb_tmr_q[g]  <= '0;
					fb_trip_q[g] <= 1'b0;
				end else begin
					if (!fb_run[g] || fb_chg) begin
						fb_tmr_q[g] <= '0;
					end else if (tick_q && fb_tmr_q[g] != '1) begin
						fb_tmr_q[g] <= fb_tmr_q[g] + TW'(1);
					end
					fb_trip_q[g] <= fb_run[g] && !fb_chg && (fb_tmr_q[g] >= fb_wait_i);
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fb_prev_q <= {2{dsi_pkg::LVL_RST}};
		end else begin
			fb_prev_q <= lvl[CH_B+1:CH_B];
		end
	end

	assign func_exec_o  = exec_q;
	assign index_o      = index_q;
	assign fs_status_o  = fs_q;
	assign fb_trip_o    = fb_trip_q;
	assign in_level_o   = lvl_out_q;
	assign err_o        = err_q;
	assign safe_state_o = safe_q;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);

	a_err_sticky: assert property ((err_q & $past(err_q)) == $past(err_q))
		else $error("latched error cleared");
	a_safe_follows: assert property ((|err_q) |=> safe_state_o)
		else $error("safe state missing after error");
	a_cross_input: assert property ((tp_en_i[0] && in_pulse[0] && in_pulse[1]) |=> err_q[EC])
		else $error("cross circuit not flagged");
	a_brake_cross: assert property ((bfb_mode_i == dsi_pkg::BM_CROSS && in_pulse[CH_B]
		&& in_pulse[CH_B+1]) |=> err_q[EC+3])
		else $error("brake cross circuit not flagged");
	a_brake_sep: assert property ($rose(err_q[EC+3]) |-> $past(bfb_mode_i == dsi_pkg::BM_CROSS))
		else $error("brake cross flagged outside cross mode");
	a_disc_tol: assert property ($rose(err_q[ED]) |-> $past(disc[0] && tol_q[0] > tol_ticks_i[0]))
		else $error("discrepancy flagged before tolerance");
	a_fs_set_wins: assert property (fs_set_i |=> fs_status_o)
		else $error("fail-safe set lost");
	a_fs_clear: assert property ((!fs_set_i && exec_d[dsi_pkg::F_FS_RESET]) |=> !fs_status_o)
		else $error("fail-safe reset ignored");
	a_and_link: assert property ((sel_first_i[0] == dsi_pkg::F_TORQUE_OFF && !ok_lvl[0])
		|=> func_exec_o[dsi_pkg::F_TORQUE_OFF])
		else $error("request of one linked input lost");
endmodule

// ---- dsi_field_model.sv ----
`timescale 1ns/1ps
module dsi_field_model (
	input  wire logic [2:0] req_i,
	input  wire logic [2:0] antival_i,
	input  wire logic [2:0] dark_a_i,
	input  wire logic [2:0] dark_b_i,
	input  wire logic [1:0] bfb_dark_i,
	output logic      [2:0] chan_a_o,
	output logic      [2:0] chan_b_o,
	output logic      [1:0] bfb_o
);
	// A request pulls channel a to 0V; channel b follows the wiring mode
	assign chan_a_o = ~req_i & ~dark_a_i;
	assign chan_b_o = (antival_i ^ ~req_i) & ~dark_b_i;
	// Contacts idle at 24V and drop only for a commanded dark time
	assign bfb_o    = ~bfb_dark_i;
endmodule

// ---- dsi_top_test.sv ----
`timescale 1ns/1ps
module dsi_top_test;
	localparam int TC = 4;
	logic                           mclk = 1'b0;
	logic                           nrst = 1'b0;
	logic [2:0]                     req, antival, dark_a, dark_b, tp_en, chan_a, chan_b;
	logic [1:0]                     bfb_dark, bfb, trip;
	logic [3:0][dsi_pkg::TW-1:0]    filt;
	logic [2:0][dsi_pkg::TW-1:0]    tol;
	logic [dsi_pkg::TW-1:0]         period, pulse, fb_wait;
	dsi_pkg::dsi_bmode_t            bmode;
	dsi_pkg::dsi_func_t             sel1 [dsi_pkg::N_IN];
	dsi_pkg::dsi_func_t             sel2 [dsi_pkg::N_IN];
	dsi_pkg::dsi_bdiag_t            diag [4];
	logic [1:0][1:0]                lvl;
	logic                           fs_set, fs_st, safe;
	logic [dsi_pkg::N_FUNC-1:0]     fexec;
	logic [2:0]                     idx, in_lvl;
	logic [dsi_pkg::E_W-1:0]        err;
	int                             bad_count = 0;
	int                             n_checks = 0;

	always #4 mclk = ~mclk;

	dsi_field_model field_u (.req_i(req), .antival_i(antival), .dark_a_i(dark_a),
		.dark_b_i(dark_b), .bfb_dark_i(bfb_dark), .chan_a_o(chan_a), .chan_b_o(chan_b),
		.bfb_o(bfb));

	dsi_top #(.TICK_CYC(TC)) dut_u (.mclk_i(mclk), .nrst_i(nrst), .chan_a_i(chan_a),
		.chan_b_i(chan_b), .bfb_i(bfb), .filt_ticks_i(filt), .tol_ticks_i(tol),
		.tp_period_i(period), .tp_pulse_i(pulse), .tp_en_i(tp_en), .bfb_mode_i(bmode),
		.antival_i(antival), .sel_first_i(sel1), .sel_second_i(sel2), .bfb_lvl_i(lvl),
		.bfb_diag_i(diag), .fb_wait_i(fb_wait), .fs_set_i(fs_set), .func_exec_o(fexec),
		.index_o(idx), .fs_status_o(fs_st), .fb_trip_o(trip), .in_level_o(in_lvl),
		.err_o(err), .safe_state_o(safe));

	task automatic close_out();
		if (bad_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	function automatic logic pick(input int w, input int b);
		case (w)
			0: return fexec[b];
			1: return err[b];
			default: return trip[b];
		endcase
	endfunction

	task automatic wait_hi(input int w, input int b, input int lim);
		int k;
		k = 0;
		while (k < lim && pick(w, b) !== 1'b1) begin
			cyc(1);
			k++;
		end
		if (pick(w, b) !== 1'b1) begin
			bad_count++;
			$display("wrong value at %0t: wait ran out", $time);
			close_out();
		end
	endtask

	// Short times in ticks so every scenario settles in tens of cycles
	task automatic cfg();
		{req, antival, dark_a, dark_b, bfb_dark, tp_en} = '0;
		filt = {4{20'h00001}};
		tol = {3{20'h00005}};
		period = 20'h003E8;
		pulse = 20'h00003;
		fb_wait = 20'h00005;
		bmode = dsi_pkg::BM_OFF;
		lvl = '0;
		fs_set = 1'b0;
		for (int i = 0; i < 3; i++) begin
			sel1[i] = dsi_pkg::F_NONE;
			sel2[i] = dsi_pkg::F_NONE;
		end
		for (int i = 0; i < 4; i++) begin
			diag[i] = dsi_pkg::BD_OFF;
		end
	endtask

	task automatic start();
		nrst = 1'b0;
		cyc(16);
		nrst = 1'b1;
		cyc(40);
	endtask

	task automatic s_basic();
		cfg();
		sel1[0] = dsi_pkg::F_TORQUE_OFF;
		start();
		chk(in_lvl, 3'h7);
		chk(fexec, 0);
		chk({err, safe}, 0);
	endtask

	task automatic s_filter();
		cfg();
		filt[0] = 20'h00003;
		filt[1] = 20'h00008;
		sel1[0] = dsi_pkg::F_TORQUE_OFF;
		sel1[1] = dsi_pkg::F_BRAKE_CTRL;
		start();
		req[0] = 1'b1;
		cyc(4);
		req[0] = 1'b0;
		cyc(20);
		chk(fexec[1], 0);
		req[1:0] = 2'h3;
		cyc(8);
		chk(fexec[2:1], 0);
		wait_hi(0, 1, 40);
		chk(fexec[2], 0);
		wait_hi(0, 2, 60);
		chk(in_lvl[1:0], 0);
	endtask

	task automatic s_and();
		cfg();
		sel1[0] = dsi_pkg::F_STOP_ONE;
		sel2[1] = dsi_pkg::F_STOP_ONE;
		sel2[0] = dsi_pkg::F_DOOR_LOCK;
		start();
		req = 3'h2;
		cyc(24);
		chk(fexec, 32'h00000001 << dsi_pkg::F_STOP_ONE);
		req = 3'h1;
		cyc(30);
		chk(fexec, 32'h00000048);
	endtask

	task automatic s_codes();
		cfg();
		start();
		for (int c = 1; c < dsi_pkg::N_FUNC; c++) begin
			if (c >= 8 && c <= 13) continue;
			sel1[0] = dsi_pkg::dsi_func_t'(c);
			req[0] = 1'b1;
			cyc(20);
			chk(fexec, 32'h00000001 << c);
			req[0] = 1'b0;
			cyc(20);
		end
	endtask

	task automatic s_antival();
		cfg();
		antival = 3'h4;
		sel1[2] = dsi_pkg::F_LIM_ACCEL;
		start();
		chk({in_lvl[2], fexec}, 32'h00040000);
		req[2] = 1'b1;
		cyc(24);
		chk(fexec, 32'h00000001 << dsi_pkg::F_LIM_ACCEL);
		chk(err, 0);
	endtask

	task automatic s_disc();
		cfg();
		start();
		dark_b[2] = 1'b1;
		cyc(12);
		chk(err, 0);
		wait_hi(1, dsi_pkg::E_DISC + 2, 60);
		cyc(2);
		chk(safe, 1);
		dark_b[2] = 1'b0;
		cyc(30);
		chk({err[dsi_pkg::E_DISC+2], safe}, 2'h3);
	endtask

	task automatic s_pulse();
		logic seen;
		cfg();
		tp_en = 3'h1;
		sel1[0] = dsi_pkg::F_TORQUE_OFF;
		start();
		seen = 1'b0;
		for (int k = 0; k < 60; k++) begin
			dark_a[0] = (k < 12);
			dark_b[0] = (k >= 30 && k < 42);
			cyc(1);
			seen |= fexec[1];
		end
		chk(seen, 0);
		chk(err, 0);
		req[0] = 1'b1;
		cyc(10);
		chk(fexec[1], 0);
		wait_hi(0, 1, 30);
	endtask

	task automatic s_cross();
		cfg();
		tp_en = 3'h1;
		start();
		{dark_a[0], dark_b[0]} = 2'h3;
		cyc(12);
		{dark_a[0], dark_b[0]} = 2'h0;
		wait_hi(1, dsi_pkg::E_CROSS, 10);
		cyc(2);
		chk({err[dsi_pkg::E_CROSS+1], safe}, 2'h1);
	endtask

	task automatic s_miss();
		cfg();
		tp_en = 3'h1;
		period = 20'h0001E;
		start();
		dark_a[0] = 1'b1;
		cyc(8);
		dark_a[0] = 1'b0;
		cyc(50);
		chk(err, 0);
		wait_hi(1, dsi_pkg::E_MISS, 80);
		cyc(2);
		chk(err[dsi_pkg::E_MISS+2:dsi_pkg::E_MISS+1], 0);
		chk(safe, 1);
	endtask

	task automatic s_brake_mode();
		for (int i = 0; i < 2; i++) begin
			cfg();
			bmode = i ? dsi_pkg::BM_SEPARATE : dsi_pkg::BM_CROSS;
			start();
			bfb_dark = 2'h3;
			cyc(12);
			bfb_dark = 2'h0;
			cyc(4);
			chk(err[dsi_pkg::E_CROSS+3], i == 0);
		end
	endtask

	task automatic s_brake_check();
		cfg();
		diag[0] = dsi_pkg::BD_CHECK_A;
		diag[3] = dsi_pkg::BD_CHECK_B;
		lvl[1][1] = 1'b1;
		start();
		chk(trip, 2'h2);
		bfb_dark[0] = 1'b1;
		cyc(8);
		chk(trip[0], 0);
		wait_hi(2, 0, 60);
	endtask

	task automatic s_fs_index();
		cfg();
		sel1[0] = dsi_pkg::F_FS_RESET;
		sel1[1] = dsi_pkg::F_IDX1;
		sel1[2] = dsi_pkg::F_IDX2;
		start();
		fs_set = 1'b1;
		cyc(1);
		fs_set = 1'b0;
		cyc(3);
		chk({fs_st, idx}, 4'hE);
		req = 3'h5;
		cyc(24);
		chk({fs_st, idx}, 4'h2);
		cfg();
		sel1[0] = dsi_pkg::F_IDX0;
		sel1[2] = dsi_pkg::F_IDX2;
		req = 3'h2;
		cyc(24);
		chk(idx, 3'h5);
	endtask

	initial begin
		cfg();
		s_basic();
		s_filter();
		s_and();
		s_codes();
		s_antival();
		s_disc();
		s_pulse();
		s_cross();
		s_miss();
		s_brake_mode();
		s_brake_check();
		s_fs_index();
		close_out();
	end
endmodule
